// ==== rtl/dlb_ctl_if.sv ====
// Purpose: effective control bits passed from register file to datapath muxes
// Assumes: single clock domain
// Notes:   driven by the top, read by the mux module
`timescale 1ns/100ps
interface dlb_ctl_if;
    logic remote_loop_eff;
    logic bypass_eff;
    logic scrub_eff;
    logic local_loop_eff;
    logic repeat_filter_off;
    modport ctl (output remote_loop_eff, output bypass_eff, output scrub_eff,
                 output local_loop_eff, output repeat_filter_off);
    modport mux (input remote_loop_eff, input bypass_eff, input scrub_eff,
                 input local_loop_eff, input repeat_filter_off);
endinterface : dlb_ctl_if

// ==== rtl/dlb_mux.sv ====
// Purpose: datapath selection for bypass, remote loop and framer loopback
// Assumes: all inputs on aclk
// Notes:   outputs registered
`timescale 1ns/100ps
module dlb_mux #(
    parameter int W = dlb_pkg::BYTE_W
) (
    // clock and reset
    input  wire logic         aclk,
    input  wire logic         aresetn,
    // controls
    dlb_ctl_if.mux            ctl,
    // datapath
    input  wire logic [W-1:0] line_byte_in,
    input  wire logic [W-1:0] tx_byte_in,
    input  wire logic [W-1:0] rx_path_byte,
    input  wire logic [W-1:0] tx_path_byte,
    output logic      [W-1:0] rx_byte_out,
    output logic      [W-1:0] tx_path_sel,
    output logic      [W-1:0] framer_in,
    output logic              repeat_filter_run
);
    // receive output: idle, transmit input, or receive path data
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rx_byte_out <= '0;
        end else if (ctl.bypass_eff && ctl.scrub_eff) begin
            rx_byte_out <= W'(dlb_pkg::IDLE_PAIR);
        end else if (ctl.bypass_eff) begin
            rx_byte_out <= tx_byte_in;
        end else begin
            rx_byte_out <= rx_path_byte;
        end
    end

    // transmit path source: received symbols when remote loop is in force
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tx_path_sel <= '0;
        end else begin
            tx_path_sel <= ctl.remote_loop_eff ? rx_path_byte : tx_byte_in;
        end
    end

    // framer input: looped transmit data during local loop or self test
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            framer_in <= '0;
        end else begin
            framer_in <= ctl.local_loop_eff ? tx_path_byte : line_byte_in;
        end
    end

    // repeat filter enable
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            repeat_filter_run <= 1'b0;
        end else begin
            repeat_filter_run <= !ctl.repeat_filter_off;
        end
    end
endmodule // dlb_mux

// ==== rtl/dlb_pkg.sv ====
// Purpose: shared constants for the datapath loop/bypass/self-test control block
// Assumes: axi4-lite register access, 32-bit data, one clock
// Notes:   offsets are byte addresses
package dlb_pkg;
    // register byte offsets
    localparam logic [7:0] CTRL_A_OFS   = 8'h00;
    localparam logic [7:0] CTRL_B_OFS   = 8'h04;
    localparam logic [7:0] STATUS_OFS   = 8'h08;
    localparam logic [7:0] INT_STAT_OFS = 8'h0c;
    localparam logic [7:0] INT_MASK_OFS = 8'h10;
    // control a field positions
    localparam int SELFTEST_RUN_BIT  = 0;
    localparam int REPEAT_FILT_BIT   = 1;
    localparam int REMOTE_LOOP_BIT   = 2;
    localparam int BYPASS_BIT        = 3;
    localparam int LM_LOOP_BIT       = 4;
    localparam int EB_LOOP_BIT       = 5;
    localparam int SCRUB_BIT         = 6;
    localparam int CIPHER_LOOP_BIT   = 7;
    localparam int CTRL_A_WIDTH      = 8;
    // control b field positions
    localparam int CONFIG_OVR_BIT    = 15;
    // interrupt status field positions
    localparam int INT_DONE_BIT      = 0;
    localparam int INT_ABORT_BIT     = 1;
    localparam int INT_WIDTH         = 2;
    // reset values
    localparam logic [CTRL_A_WIDTH-1:0] CTRL_A_RST = 8'h00;
    localparam logic                    CFG_RST    = 1'b0;
    localparam logic [INT_WIDTH-1:0]    INT_RST    = 2'h0;
    // self-test length in cycles
    localparam int SELFTEST_CYCLES   = 1024;
    // axi responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // byte symbol width (two 5-bit symbols)
    localparam int BYTE_W            = 10;
    // idle symbol pair
    localparam logic [BYTE_W-1:0] IDLE_PAIR = 10'h3ff;
    // self-test engine states
    typedef enum logic [1:0] {
        DLB_ST_IDLE = 2'b00,
        DLB_ST_RUN  = 2'b01,
        DLB_ST_DONE = 2'b11
    } dlb_st_t;
endpackage : dlb_pkg

// ==== rtl/dlb_top.sv ====
// Purpose: loopback, bypass, repeat filter and self-test control with axi4-lite registers
// Assumes: one 250 MHz clock, synchronous active-low reset
// Notes:   self-test engine is a fixed-length run with done interrupt
`timescale 1ns/100ps

// Summary of operation
// - effective remote loop sends received symbols into transmit path
// - remote loop mux follows bit only in maintenance or with override
// - remote loop ignored while any local or cipher loop bit set
// - remote loop bit writable anytime, held, applied when gating allows
// - connection management may use remote loop during normal operation
// - repeat filter off bit stops the repeat filter state machine
// - setting self-test run starts test; completion raises interrupt
// - clearing self-test run aborts a running test
// - bypass: idle with scrub, transmit input without, else receive path data
// - override makes scrub, bypass, remote loop act in any state
// - during self test the framer loopback path is established
module dlb_top #(
    parameter int W          = dlb_pkg::BYTE_W,
    parameter int TEST_CYCLES = dlb_pkg::SELFTEST_CYCLES
) (
    // clock and reset
    input  wire logic         aclk,
    input  wire logic         aresetn,
    // axi4-lite write address
    input  wire logic [7:0]   s_axi_awaddr,
    input  wire logic         s_axi_awvalid,
    output logic              s_axi_awready,
    // axi4-lite write data
    input  wire logic [31:0]  s_axi_wdata,
    input  wire logic [3:0]   s_axi_wstrb,
    input  wire logic         s_axi_wvalid,
    output logic              s_axi_wready,
    // axi4-lite write response
    output logic [1:0]        s_axi_bresp,
    output logic              s_axi_bvalid,
    input  wire logic         s_axi_bready,
    // axi4-lite read address
    input  wire logic [7:0]   s_axi_araddr,
    input  wire logic         s_axi_arvalid,
    output logic              s_axi_arready,
    // axi4-lite read data
    output logic [31:0]       s_axi_rdata,
    output logic [1:0]        s_axi_rresp,
    output logic              s_axi_rvalid,
    input  wire logic         s_axi_rready,
    // connection management state
    input  wire logic         maintenance_state,
    input  wire logic         cm_remote_loop_req,
    // datapath
    input  wire logic [W-1:0] line_symbol_in,
    input  wire logic [W-1:0] tx_byte_in,
    input  wire logic [W-1:0] rx_path_byte,
    input  wire logic [W-1:0] tx_path_byte,
    output logic      [W-1:0] rx_byte_out,
    output logic      [W-1:0] tx_path_sel,
    output logic      [W-1:0] framer_in,
    output logic              repeat_filter_run,
    // self-test status and interrupt
    output logic              selftest_busy,
    output logic              irq
);
    // control registers
    logic [dlb_pkg::CTRL_A_WIDTH-1:0] ctrl_a;
    logic                             config_override;
    logic [dlb_pkg::INT_WIDTH-1:0]    int_stat;
    logic [dlb_pkg::INT_WIDTH-1:0]    int_mask;
    logic [dlb_pkg::INT_WIDTH-1:0]    int_clr;
    // write channel holding
    logic        aw_hold;
    logic        w_hold;
    logic [7:0]  aw_addr;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic        wr_fire;
    logic        wr_addr_ok;
    // synchronised connection management inputs
    logic [1:0]  maintenance_state_sync;
    logic [1:0]  cmreq_sync;
    logic        gate_ok;
    // self-test engine
    dlb_pkg::dlb_st_t st;
    logic [$clog2(TEST_CYCLES+1)-1:0] st_cnt;
    logic        run_prev;
    logic        ev_done;
    logic        ev_abort;
    logic        run_bit;
    logic        any_local;
    logic        st_running;
    logic        st_last;

    dlb_ctl_if ctl_bus ();

    // register bit taps, write strobe and self-test state flags
    assign run_bit   = ctrl_a[dlb_pkg::SELFTEST_RUN_BIT];
    assign wr_fire   = aw_hold && w_hold && !s_axi_bvalid;
    assign st_running = (st == dlb_pkg::DLB_ST_RUN);
    assign st_last    = (st_cnt == ($clog2(TEST_CYCLES+1))'(TEST_CYCLES - 1));
    // gate for scrub, bypass and remote loop
    assign gate_ok   = maintenance_state_sync[1] || config_override;
    assign any_local = ctrl_a[dlb_pkg::EB_LOOP_BIT] || ctrl_a[dlb_pkg::LM_LOOP_BIT]
                       || ctrl_a[dlb_pkg::CIPHER_LOOP_BIT];

    // effective control bits
    assign ctl_bus.remote_loop_eff = !any_local &&
        ((gate_ok && ctrl_a[dlb_pkg::REMOTE_LOOP_BIT])
         || cmreq_sync[1]);
    assign ctl_bus.bypass_eff        = gate_ok && ctrl_a[dlb_pkg::BYPASS_BIT];
    assign ctl_bus.scrub_eff         = gate_ok && ctrl_a[dlb_pkg::SCRUB_BIT];
    assign ctl_bus.local_loop_eff    = ctrl_a[dlb_pkg::EB_LOOP_BIT]
                                       || st_running;
    assign ctl_bus.repeat_filter_off = ctrl_a[dlb_pkg::REPEAT_FILT_BIT];

    // write address decode: every mapped word answers okay
    assign wr_addr_ok = (aw_addr == dlb_pkg::CTRL_A_OFS)
                        || (aw_addr == dlb_pkg::CTRL_B_OFS)
                        || (aw_addr == dlb_pkg::STATUS_OFS)
                        || (aw_addr == dlb_pkg::INT_STAT_OFS)
                        || (aw_addr == dlb_pkg::INT_MASK_OFS);

    // write-one-to-clear pattern for the interrupt status word
    assign int_clr = (wr_fire && aw_addr == dlb_pkg::INT_STAT_OFS && w_strb[0])
                     ? w_data[dlb_pkg::INT_WIDTH-1:0] : {dlb_pkg::INT_WIDTH{1'b0}};

    // two-flop synchronisers for outside inputs
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            maintenance_state_sync <= 2'h0;
            cmreq_sync <= 2'h0;
        end else begin
            maintenance_state_sync <= {maintenance_state_sync[0], maintenance_state};
            cmreq_sync <= {cmreq_sync[0], cm_remote_loop_req};
        end
    end

    // write address and data capture, either order
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_hold <= 1'b0;
            w_hold  <= 1'b0;
            aw_addr <= 8'h00;
            w_data  <= 32'h0000_0000;
            w_strb  <= 4'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_hold <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end else if (wr_fire) begin
                aw_hold <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_hold <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end else if (wr_fire) begin
                w_hold <= 1'b0;
            end
        end
    end

    // ready and write response
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= dlb_pkg::RESP_OKAY;
        end else begin
            s_axi_awready <= !aw_hold && !(s_axi_awvalid && s_axi_awready) && !s_axi_bvalid;
            s_axi_wready  <= !w_hold && !(s_axi_wvalid && s_axi_wready) && !s_axi_bvalid;
            if (wr_fire) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_addr_ok ? dlb_pkg::RESP_OKAY : dlb_pkg::RESP_SLVERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // control register writes
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_a          <= dlb_pkg::CTRL_A_RST;
            config_override <= dlb_pkg::CFG_RST;
            int_mask        <= dlb_pkg::INT_RST;
        end else if (wr_fire) begin
            if (aw_addr == dlb_pkg::CTRL_A_OFS && w_strb[0]) begin
                ctrl_a <= w_data[dlb_pkg::CTRL_A_WIDTH-1:0];
            end
            if (aw_addr == dlb_pkg::CTRL_B_OFS && w_strb[1]) begin
                config_override <= w_data[dlb_pkg::CONFIG_OVR_BIT];
            end
            if (aw_addr == dlb_pkg::INT_MASK_OFS && w_strb[0]) begin
                int_mask <= w_data[dlb_pkg::INT_WIDTH-1:0];
            end
        end
    end

    // self-test engine: starts on rising edge of run bit only
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st       <= dlb_pkg::DLB_ST_IDLE;
            st_cnt   <= '0;
            run_prev <= 1'b0;
            ev_done  <= 1'b0;
            ev_abort <= 1'b0;
        end else begin
            run_prev <= run_bit;
            ev_done  <= 1'b0;
            ev_abort <= 1'b0;
            unique case (st)
                dlb_pkg::DLB_ST_IDLE: begin
                    if (run_bit && !run_prev) begin
                        st     <= dlb_pkg::DLB_ST_RUN;
                        st_cnt <= '0;
                    end
                end
                dlb_pkg::DLB_ST_RUN: begin
                    if (!run_bit) begin
                        st       <= dlb_pkg::DLB_ST_IDLE;
                        ev_abort <= 1'b1;
                    end else if (st_last) begin
                        st      <= dlb_pkg::DLB_ST_DONE;
                        ev_done <= 1'b1;
                    end else begin
                        st_cnt <= st_cnt + 1'b1;
                    end
                end
                dlb_pkg::DLB_ST_DONE: begin
                    if (!run_bit) begin
                        st <= dlb_pkg::DLB_ST_IDLE;
                    end
                end
                default: st <= dlb_pkg::DLB_ST_IDLE;
            endcase
        end
    end

    // sticky interrupt status, write one to clear, set wins
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            int_stat <= dlb_pkg::INT_RST;
        end else begin
            int_stat <= (int_stat & ~int_clr) | {ev_abort, ev_done}; // set wins
        end
    end

    // interrupt and busy outputs
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq           <= 1'b0;
            selftest_busy <= 1'b0;
        end else begin
            irq           <= |(int_stat & int_mask);
            selftest_busy <= st_running;
        end
    end

    // read channel
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= dlb_pkg::RESP_OKAY;
        end else begin
            s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp  <= dlb_pkg::RESP_OKAY;
                s_axi_rdata  <= 32'h0000_0000;
                unique case (s_axi_araddr)
                    dlb_pkg::CTRL_A_OFS:   s_axi_rdata[dlb_pkg::CTRL_A_WIDTH-1:0] <= ctrl_a;
                    dlb_pkg::CTRL_B_OFS:   s_axi_rdata[dlb_pkg::CONFIG_OVR_BIT] <= config_override;
                    dlb_pkg::STATUS_OFS:   s_axi_rdata[4:0] <= {ctl_bus.scrub_eff,
                        ctl_bus.bypass_eff, ctl_bus.remote_loop_eff, st};
                    dlb_pkg::INT_STAT_OFS: s_axi_rdata[dlb_pkg::INT_WIDTH-1:0] <= int_stat;
                    dlb_pkg::INT_MASK_OFS: s_axi_rdata[dlb_pkg::INT_WIDTH-1:0] <= int_mask;
                    default:               s_axi_rresp <= dlb_pkg::RESP_SLVERR;
                endcase
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // datapath multiplexers
    dlb_mux #(
        .W (W)
    ) u_mux (
        .aclk              (aclk),
        .aresetn           (aresetn),
        .ctl               (ctl_bus.mux),
        .line_byte_in      (line_symbol_in),
        .tx_byte_in        (tx_byte_in),
        .rx_path_byte      (rx_path_byte),
        .tx_path_byte      (tx_path_byte),
        .rx_byte_out       (rx_byte_out),
        .tx_path_sel       (tx_path_sel),
        .framer_in         (framer_in),
        .repeat_filter_run (repeat_filter_run)
    );
endmodule // dlb_top

// ==== test/dlb_top_sva.sv ====
// Purpose: port-level checks for dlb_top
// Assumes: one clock, synchronous active-low reset
// Notes:   bound into every dlb_top instance
`timescale 1ns/100ps
module dlb_chk #(
    parameter int W           = dlb_pkg::BYTE_W,
    parameter int TEST_CYCLES = dlb_pkg::SELFTEST_CYCLES
) (
    // clock and reset
    input wire logic         aclk,
    input wire logic         aresetn,
    // register bus responses
    input wire logic         s_axi_bvalid,
    input wire logic         s_axi_bready,
    input wire logic [31:0]  s_axi_rdata,
    input wire logic         s_axi_rvalid,
    input wire logic         s_axi_rready,
    // datapath
    input wire logic [W-1:0] line_symbol_in,
    input wire logic [W-1:0] tx_byte_in,
    input wire logic [W-1:0] rx_path_byte,
    input wire logic [W-1:0] tx_path_byte,
    input wire logic [W-1:0] rx_byte_out,
    input wire logic [W-1:0] tx_path_sel,
    input wire logic [W-1:0] framer_in,
    // self-test status
    input wire logic         selftest_busy,
    input wire logic         irq
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    int unsigned busy_len;

    // length of the current busy stretch
    always_ff @(posedge aclk) begin
        if (!aresetn || !selftest_busy) busy_len <= 0;
        else busy_len <= busy_len + 1;
    end

    a_reset_quiet: assert property ($rose(aresetn) |-> !selftest_busy && !irq)
        else $error("busy or irq after reset");
    a_bresp_held: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write response dropped");
    a_rdata_held: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data not held");
    a_txsel_source: assert property ($past(aresetn) |->
        tx_path_sel == $past(rx_path_byte) || tx_path_sel == $past(tx_byte_in))
        else $error("transmit path from unknown source");
    a_rxout_source: assert property ($past(aresetn) |->
        rx_byte_out == dlb_pkg::IDLE_PAIR ||
        rx_byte_out == $past(tx_byte_in) || rx_byte_out == $past(rx_path_byte))
        else $error("receive output from unknown source");
    a_framer_source: assert property ($past(aresetn) |->
        framer_in == $past(tx_path_byte) || framer_in == $past(line_symbol_in))
        else $error("framer input from unknown source");
    a_framer_test_loop: assert property ($past(selftest_busy) && selftest_busy |->
        framer_in == $past(tx_path_byte))
        else $error("no framer loop during self test");
    a_busy_bounded: assert property (busy_len <= TEST_CYCLES + 1)
        else $error("self test runs too long");

    c_test_start: cover property ($rose(selftest_busy));
    c_irq_raised: cover property ($rose(irq));
    c_idle_sent: cover property (rx_byte_out == dlb_pkg::IDLE_PAIR);
endmodule // dlb_chk

bind dlb_top dlb_chk #(.W(W), .TEST_CYCLES(TEST_CYCLES)) u_chk (
    .aclk(aclk), .aresetn(aresetn), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .line_symbol_in(line_symbol_in), .tx_byte_in(tx_byte_in), .rx_path_byte(rx_path_byte),
    .tx_path_byte(tx_path_byte), .rx_byte_out(rx_byte_out), .tx_path_sel(tx_path_sel),
    .framer_in(framer_in), .selftest_busy(selftest_busy), .irq(irq));

// ==== test/dlb_top_tb_top.sv ====
// Purpose: self-checking bench for dlb_top
// Assumes: axi4-lite master in the bench, 4 ns clock, short self test
// Notes:   datapath inputs held at distinct constants
`timescale 1ns/100ps
module dlb_top_tb_top;
    localparam int TC = 8;
    logic        aclk, aresetn, maintenance_state, cm_remote_loop_req;
    logic [7:0]  s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
    logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic        repeat_filter_run, selftest_busy, irq;
    logic [9:0]  line_symbol_in, tx_byte_in, rx_path_byte, tx_path_byte;
    logic [9:0]  rx_byte_out, tx_path_sel, framer_in;
    int          n_errors, samples_checked;

    dlb_top #(.TEST_CYCLES(TC)) dut (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
        .maintenance_state(maintenance_state), .cm_remote_loop_req(cm_remote_loop_req),
        .line_symbol_in(line_symbol_in), .tx_byte_in(tx_byte_in), .rx_path_byte(rx_path_byte),
        .tx_path_byte(tx_path_byte), .rx_byte_out(rx_byte_out), .tx_path_sel(tx_path_sel),
        .framer_in(framer_in), .repeat_filter_run(repeat_filter_run),
        .selftest_busy(selftest_busy), .irq(irq));

    task automatic wrap_up();
        $display("mismatches %0d, checks %0d", n_errors, samples_checked);
        if (n_errors == 0 && samples_checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        samples_checked++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch at %0t: %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic hang(input string what);
        n_errors++;
        $display("mismatch at %0t: timeout on %s", $time, what);
        wrap_up();
    endtask

    task automatic settle();
        repeat (5) @(posedge aclk);
    endtask

    task automatic wait_sig(ref logic s, input logic v, input string what);
        for (int k = 0; k < 40 && s !== v; k++) @(posedge aclk);
        if (s !== v) hang(what);
    endtask

    // write one word, responses accepted only after bvalid is seen
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
                          input logic [1:0] er = dlb_pkg::RESP_OKAY);
        @(posedge aclk);
        s_axi_awaddr  <= a;
        s_axi_wdata   <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        for (int k = 0; k < 40 && !s_axi_bvalid; k++) begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end
        if (!s_axi_bvalid) hang("write");
        s_axi_bready <= 1'b1;
        @(posedge aclk);
        s_axi_bready <= 1'b0;
        chk(s_axi_bresp, er, "bresp");
    endtask

    // read one word and compare data and response
    task automatic axi_rd(input logic [7:0] a, input logic [31:0] e,
                          input logic [1:0] er = dlb_pkg::RESP_OKAY);
        @(posedge aclk);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        for (int k = 0; k < 40 && !s_axi_rvalid; k++) begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end
        if (!s_axi_rvalid) hang("read");
        s_axi_rready <= 1'b1;
        @(posedge aclk);
        s_axi_rready <= 1'b0;
        chk(s_axi_rdata, e, "rdata");
        chk(s_axi_rresp, er, "rresp");
    endtask

    task automatic t_reset();
        chk(repeat_filter_run, 1'b1, "filter at reset");
        chk({selftest_busy, irq}, 2'h0, "idle at reset");
        chk(framer_in, line_symbol_in, "framer at reset");
        chk(tx_path_sel, tx_byte_in, "tx path at reset");
        axi_rd(8'h00, 32'h0);
        axi_rd(8'h04, 32'h0);
        axi_rd(8'h0c, 32'h0);
        axi_rd(8'h08, 32'h0);
        axi_rd(8'h10, 32'h0);
        axi_rd(8'h14, 32'h0, dlb_pkg::RESP_SLVERR);
        axi_wr(8'h14, 32'h1, dlb_pkg::RESP_SLVERR);
    endtask

    task automatic t_remote();
        logic [31:0] lp [3] = '{32'h24, 32'h14, 32'h84};
        axi_wr(8'h00, 32'h04);
        settle();
        chk(tx_path_sel, tx_byte_in, "loop gated");
        axi_rd(8'h00, 32'h04);
        maintenance_state <= 1'b1;
        settle();
        chk(tx_path_sel, rx_path_byte, "loop in maintenance");
        axi_rd(8'h08, 32'h4);
        foreach (lp[i]) begin
            axi_wr(8'h00, lp[i]);
            settle();
            chk(tx_path_sel, tx_byte_in, "loop blocked");
        end
        maintenance_state <= 1'b0;
        axi_wr(8'h00, 32'h04);
        axi_wr(8'h04, 32'h8000);
        settle();
        chk(tx_path_sel, rx_path_byte, "loop by override");
        axi_wr(8'h04, 32'h0);
        axi_wr(8'h00, 32'h0);
        cm_remote_loop_req <= 1'b1;
        settle();
        chk(tx_path_sel, rx_path_byte, "management loop");
        cm_remote_loop_req <= 1'b0;
    endtask

    task automatic t_bypass();
        logic [31:0] ca [4] = '{32'h08, 32'h48, 32'h48, 32'h40};
        logic [31:0] cb [4] = '{32'h8000, 32'h8000, 32'h0, 32'h8000};
        logic [9:0]  ex [4] = '{tx_byte_in, dlb_pkg::IDLE_PAIR, rx_path_byte, rx_path_byte};
        for (int i = 0; i < 4; i++) begin
            axi_wr(8'h04, cb[i]);
            axi_wr(8'h00, ca[i]);
            settle();
            chk(rx_byte_out, ex[i], "bypass output");
        end
        axi_wr(8'h00, 32'h02);
        settle();
        chk(repeat_filter_run, 1'b0, "filter stopped");
        axi_wr(8'h00, 32'h0);
        axi_wr(8'h04, 32'h0);
        settle();
        chk(repeat_filter_run, 1'b1, "filter running");
    endtask

    task automatic t_selftest();
        axi_wr(8'h10, 32'h3);
        axi_wr(8'h00, 32'h1);
        wait_sig(selftest_busy, 1'b1, "test start");
        @(posedge aclk);
        chk(framer_in, tx_path_byte, "framer loop");
        wait_sig(irq, 1'b1, "done irq");
        chk(selftest_busy, 1'b0, "busy after done");
        axi_rd(8'h0c, 32'h1);
        axi_rd(8'h08, 32'h3);
        axi_wr(8'h0c, 32'h1);
        repeat (3 * TC) @(posedge aclk);
        chk({selftest_busy, irq}, 2'h0, "no rerun");
        axi_wr(8'h00, 32'h0);
        axi_wr(8'h00, 32'h1);
        wait_sig(selftest_busy, 1'b1, "second start");
        axi_wr(8'h00, 32'h0);
        wait_sig(selftest_busy, 1'b0, "abort");
        wait_sig(irq, 1'b1, "abort irq");
        axi_rd(8'h0c, 32'h2);
        axi_wr(8'h10, 32'h1);
        settle();
        chk(irq, 1'b0, "masked irq");
        axi_wr(8'h10, 32'h3);
        settle();
        chk(irq, 1'b1, "unmasked irq");
        axi_wr(8'h0c, 32'h2);
        settle();
        chk(irq, 1'b0, "cleared irq");
    endtask

    // free-running clock
    initial begin
        aclk = 1'b0;
        forever #2 aclk = ~aclk;
    end

    // reset, then the scenarios
    initial begin
        aresetn = 1'b0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        {maintenance_state, cm_remote_loop_req, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        s_axi_wstrb = 4'hf;
        line_symbol_in = 10'h0a1;
        tx_byte_in = 10'h0b2;
        rx_path_byte = 10'h0c3;
        tx_path_byte = 10'h0d4;
        n_errors = 0;
        samples_checked = 0;
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        t_reset();
        t_remote();
        t_bypass();
        t_selftest();
        wrap_up();
    end
endmodule // dlb_top_tb_top
